// >>> hw/adc_port_cfg.svh
/*
   Constants of the serial conversion port: result width, serial clock counts
   that place each command bit, the sampling window and every output bit.
   Assumes it is included by bare name from the package file only; the main module does not include it.
*/
// Functional notes
// RL1 - Select low opens a transaction.
// RL2 - Select high aborts conversion, enters standby.
// RL3 - Host raises select between conversions.
// RL4 - Serial clock alone times the conversion.
// RL5 - Command captured from serial input while selected.
// RL6 - Result shifted out one bit per clock.
// RL7 - Data-out changes on falling clock edges only; the code also clears it on deselect.
// RL8 - Sample window: fourth rise, 1.5 clocks.
// RL9 - Twelve-bit straight-binary result after sampling.
// RL10 - Input pairs single-ended or pseudo-differential.
// RL11 - Host keeps serial clock above 10kHz.
// RL12 - First rise with input high is start.
// RL13 - Mode bit then three channel bits.
// RL14 - Low null bit, then result MSB first.
// RL15 - Then LSB-first resend, then zeros forever.
// RL16 - Latch on rises; deselect discards command.
`ifndef ADC_PORT_CFG_SVH
`define ADC_PORT_CFG_SVH

// Converter result width in bits.
`define RES_BITS 12
// Clock period of the block and of the serial clock in the bench, in ns.
`define MCLK_PERIOD_NS 8
`define SCLK_BENCH_PERIOD_NS 64
// Rising edge counts after the start bit (start bit itself is count 0).
`define CNT_MODE 5'h01
`define CNT_CH_HIGH 5'h02
`define CNT_CH_MID 5'h03
`define CNT_CH_LOW 5'h04
// Falling edge after this rise closes the window and drives the null bit.
`define CNT_NULL 5'h05
// Rise counts whose following fall carries result bits.
`define CNT_MSB_FIRST 5'h06
`define CNT_MSB_LAST 5'h11
`define CNT_LSB_LAST 5'h1C
// Counter saturates here; zeros are shifted from this count on.
`define CNT_ZEROS 5'h1D
// Reset values of the pin outputs.
`define SDO_RESET 1'b0
`define STANDBY_RESET 1'b1

`endif

// >>> hw/adc_port_pkg.sv
/*
   Types of the serial conversion port: sequencer states, the captured
   command and the analog multiplexer selection.
   Assumes nothing beyond the constants header.
*/
`include "adc_port_cfg.svh"

package adc_port_pkg;

   // Sequencer states: standby, hunting the start bit, command and result.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HUNT = 2'b01,
      ST_ACTIVE = 2'b10
   } state_t;

   // Command word as received after the start bit.
   typedef struct packed {
      logic input_mode_bit;
      logic channel_select_bit_high;
      logic channel_select_bit_mid;
      logic channel_select_bit_low;
   } cmd_t;

   // Selection handed to the analog multiplexer.
   typedef struct packed {
      logic [2:0] pos;
      logic [2:0] neg;
      logic neg_to_ground;
   } mux_sel_t;

endpackage

// >>> hw/pin_sync.sv
/*
   Two-flop synchroniser for a group of pins with edge detection.
   Assumes the pins are asynchronous to clk; edges show two cycles after the pin, with the level change.
*/
`timescale 1ns/1ps

module pin_sync #(
   parameter int W = 3
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Raw pins and their synchronised views.
   input wire logic [W-1:0] din,
   output logic [W-1:0] lvl,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);

   logic [W-1:0] meta_reg; // First stage, read only by the second.
   logic [W-1:0] sync_reg; // Second stage, safe to use.
   logic [W-1:0] prev_reg; // Delayed copy for edge detection.

   generate
      if (W < 1)
      begin : g_bad_width
         $error("pin_sync needs at least one pin.");
      end
   endgenerate

   // The chain resets to zero so that a pin idling high gives a rise at start.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
         prev_reg <= '0;
      end
      else
      begin
         meta_reg <= din;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // Edges compare the settled stage against its delayed copy.
   assign lvl = sync_reg;
   assign rise = sync_reg & ~prev_reg;
   assign fall = ~sync_reg & prev_reg;

endmodule

// >>> hw/serial_adc_conversion_port.sv
/*
   Serial port of a successive-approximation converter: start bit hunt,
   command capture, sampling window, null bit and bit-serial result.
   Assumes the select, serial clock and serial input pins are asynchronous
   and slow against MCLK (each serial clock phase spans several MCLK
   cycles), and that the converter core presents its code on CONV_CODE
   in the MCLK domain by the time the sampling window closes.
*/
`timescale 1ns/1ps

module serial_adc_conversion_port
   import adc_port_pkg::*;
#(
   parameter int RES_W = `RES_BITS
) (
   // Clock and reset.
   input wire logic MCLK,
   input wire logic RESETN,
   // Serial link pins.
   input wire logic SELECT_AND_SLEEP_N,
   input wire logic SCLK,
   input wire logic SDI,
   output logic SDO,
   output logic SDO_OE,
   // Converter core side.
   input wire logic [RES_W-1:0] CONV_CODE,
   output logic STANDBY,
   output logic SAMPLE_OPEN,
   output logic CONV_TAKE,
   output mux_sel_t MUX_SEL
);

   generate
      if (RES_W != `RES_BITS)
      begin : g_bad_res
         $error("Result width must match the bit schedule.");
      end
   endgenerate

   logic [2:0] pin_lvl; // Synchronised select, clock, data.
   logic [2:0] pin_rise; // Rising edges of the same.
   logic [2:0] pin_fall; // Falling edges of the same.
   logic sel_high; // Select released.
   logic sel_fall; // Select just pulled low.
   logic sclk_rise; // Serial clock rising edge seen.
   logic sclk_fall; // Serial clock falling edge seen.
   logic sdi_lvl; // Serial input, aligned with the clock view.
   state_t state_reg; // Sequencer state.
   logic [4:0] cnt_reg; // Rises counted since the start bit.
   cmd_t cmd_reg; // Captured command.
   logic [RES_W-1:0] code_reg; // Result held for shifting.
   logic out_bit; // Bit due on the next falling edge.
   logic [4:0] bit_idx; // Result index for the current count.

   // Pins cross into MCLK before anything reads them.
   pin_sync #(
      .W(3)
   ) u_pins (
      .clk(MCLK),
      .rst_n(RESETN),
      .din({SDI, SCLK, SELECT_AND_SLEEP_N}),
      .lvl(pin_lvl),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   assign sel_high = pin_lvl[0];
   assign sel_fall = pin_fall[0];
   assign sclk_rise = pin_rise[1] & ~pin_lvl[0];
   assign sclk_fall = pin_fall[1] & ~pin_lvl[0];
   assign sdi_lvl = pin_lvl[2];

   // Sequencer. Only a fresh select fall leaves standby, so a select held
   // low since reset must first go high. A high select always wins.
   always_ff @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         state_reg <= ST_IDLE;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
            begin
               if (sel_fall) // RL1
               begin
                  state_reg <= ST_HUNT;
               end
            end
            ST_HUNT:
            begin
               if (sel_high)
               begin
                  state_reg <= ST_IDLE; // RL2
               end
               else if (sclk_rise && sdi_lvl) // RL12
               begin
                  state_reg <= ST_ACTIVE;
               end
            end
            ST_ACTIVE:
            begin
               if (sel_high)
               begin
                  state_reg <= ST_IDLE; // RL2 RL16
               end
            end
            default:
            begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Rise counter: the serial clock is the only pacing of the sequence.
   always_ff @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         cnt_reg <= 5'h00;
      end
      else if (state_reg != ST_ACTIVE)
      begin
         cnt_reg <= 5'h00; // RL16
      end
      else if (sclk_rise && cnt_reg != `CNT_ZEROS) // RL4
      begin
         cnt_reg <= cnt_reg + 5'h01;
      end
   end

   // Command capture on rising edges; discarded whenever select rises.
   always_ff @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         cmd_reg <= '0;
      end
      else if (sel_high)
      begin
         cmd_reg <= '0; // RL16
      end
      else if (state_reg == ST_ACTIVE && sclk_rise) // RL5 RL13
      begin
         case (cnt_reg + 5'h01)
            `CNT_MODE: cmd_reg.input_mode_bit <= sdi_lvl;
            `CNT_CH_HIGH: cmd_reg.channel_select_bit_high <= sdi_lvl;
            `CNT_CH_MID: cmd_reg.channel_select_bit_mid <= sdi_lvl;
            `CNT_CH_LOW: cmd_reg.channel_select_bit_low <= sdi_lvl;
            default: cmd_reg <= cmd_reg;
         endcase
      end
   end

   // Multiplexer set when the last channel bit arrives, just as the
   // window opens. Single-ended uses ground as the negative input;
   // pseudo-differential pairs even and odd channels, low bit picks polarity.
   always_ff @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         MUX_SEL <= '0;
      end
      else if (state_reg == ST_ACTIVE && sclk_rise && cnt_reg + 5'h01 == `CNT_CH_LOW)
      begin
         if (cmd_reg.input_mode_bit) // RL10
         begin
            MUX_SEL.pos <= {cmd_reg.channel_select_bit_high,
                            cmd_reg.channel_select_bit_mid, sdi_lvl};
            MUX_SEL.neg <= 3'h0;
            MUX_SEL.neg_to_ground <= 1'b1;
         end
         else
         begin
            MUX_SEL.pos <= {cmd_reg.channel_select_bit_high,
                            cmd_reg.channel_select_bit_mid, sdi_lvl};
            MUX_SEL.neg <= {cmd_reg.channel_select_bit_high,
                            cmd_reg.channel_select_bit_mid, ~sdi_lvl};
            MUX_SEL.neg_to_ground <= 1'b0;
         end
      end
   end

   // Sampling window: opens on the fourth rise after the start bit and
   // closes on the fifth clock's falling edge, 1.5 serial clocks later.
   always_ff @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         SAMPLE_OPEN <= 1'b0;
      end
      else if (state_reg != ST_ACTIVE || sel_high)
      begin
         SAMPLE_OPEN <= 1'b0; // RL2
      end
      else if (sclk_rise && cnt_reg + 5'h01 == `CNT_CH_LOW)
      begin
         SAMPLE_OPEN <= 1'b1; // RL8
      end
      else if (sclk_fall && cnt_reg == `CNT_NULL)
      begin
         SAMPLE_OPEN <= 1'b0; // RL8
      end
   end

   // Result latched from the core as the window closes.
   always_ff @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         code_reg <= '0;
         CONV_TAKE <= 1'b0;
      end
      else
      begin
         CONV_TAKE <= 1'b0;
         if (state_reg == ST_ACTIVE && !sel_high && sclk_fall && cnt_reg == `CNT_NULL)
         begin
            code_reg <= CONV_CODE; // RL9
            CONV_TAKE <= 1'b1;
         end
      end
   end

   // Picks the bit for the next falling edge: MSB first, then the LSB-first
   // resend starting from bit one, then zeros.
   always_comb
   begin
      out_bit = 1'b0;
      bit_idx = 5'h00;
      if (cnt_reg >= `CNT_MSB_FIRST && cnt_reg <= `CNT_MSB_LAST)
      begin
         bit_idx = `CNT_MSB_LAST - cnt_reg; // RL14
         out_bit = code_reg[bit_idx[3:0]];
      end
      else if (cnt_reg > `CNT_MSB_LAST && cnt_reg <= `CNT_LSB_LAST)
      begin
         bit_idx = cnt_reg - `CNT_MSB_LAST; // RL15
         out_bit = code_reg[bit_idx[3:0]];
      end
   end

   // Data-out driver: moves only on falling edges; released on deselect.
   always_ff @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         SDO <= `SDO_RESET;
         SDO_OE <= 1'b0;
      end
      else if (sel_high)
      begin
         SDO <= `SDO_RESET; // RL2
         SDO_OE <= 1'b0;
      end
      else if (state_reg == ST_ACTIVE && sclk_fall) // RL7
      begin
         if (cnt_reg == `CNT_NULL)
         begin
            SDO <= 1'b0; // RL14
            SDO_OE <= 1'b1;
         end
         else if (cnt_reg > `CNT_NULL)
         begin
            SDO <= out_bit; // RL6
         end
      end
   end

   // Standby indication follows the sequencer.
   always_ff @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         STANDBY <= `STANDBY_RESET;
      end
      else
      begin
         STANDBY <= (state_reg == ST_IDLE) || sel_high; // RL2
      end
   end

   // Data-out never moves except on a falling edge or a deselect.
   a_sdo_fall_only: assert property (@(posedge MCLK) disable iff (!RESETN) // RL7
      $changed(SDO) |-> $past(sclk_fall || sel_high))
      else $error("Data-out changed away from a falling edge.");

   // Deselect puts everything in standby on the next cycle.
   a_deselect_standby: assert property (@(posedge MCLK) disable iff (!RESETN) // RL2
      sel_high |=> STANDBY && !SAMPLE_OPEN && !SDO_OE && state_reg == ST_IDLE)
      else $error("Deselect did not abort into standby.");

   // A rise with the input high while hunting starts the command.
   a_start_bit: assert property (@(posedge MCLK) disable iff (!RESETN) // RL12
      state_reg == ST_HUNT && !sel_high && sclk_rise && sdi_lvl
      |=> state_reg == ST_ACTIVE && cnt_reg == 5'h00)
      else $error("Start bit not taken.");

   // Leading zeros are ignored while hunting.
   a_leading_zero: assert property (@(posedge MCLK) disable iff (!RESETN) // RL12
      state_reg == ST_HUNT && !sel_high && sclk_rise && !sdi_lvl |=> state_reg == ST_HUNT)
      else $error("Leading zero left the hunt.");

   // Window opens on the fourth rise and is still open the cycle after.
   a_window_open: assert property (@(posedge MCLK) disable iff (!RESETN) // RL8
      state_reg == ST_ACTIVE && !sel_high && sclk_rise && cnt_reg == 5'h03
      |=> SAMPLE_OPEN ##1 SAMPLE_OPEN)
      else $error("Sampling window did not open on the fourth rise.");

   // Window closes only on the fifth clock's fall or on deselect.
   a_window_close: assert property (@(posedge MCLK) disable iff (!RESETN) // RL8
      $fell(SAMPLE_OPEN) |-> $past(sel_high || (sclk_fall && cnt_reg == `CNT_NULL)))
      else $error("Sampling window closed at the wrong moment.");

   // The driver turns on with the low null bit.
   a_null_bit: assert property (@(posedge MCLK) disable iff (!RESETN) // RL14
      $rose(SDO_OE) |-> !SDO && $past(cnt_reg) == `CNT_NULL && CONV_TAKE)
      else $error("Null bit wrong when output enabled.");

   // First result bit is the MSB of the latched code.
   a_msb_first: assert property (@(posedge MCLK) disable iff (!RESETN) // RL14
      state_reg == ST_ACTIVE && !sel_high && sclk_fall && cnt_reg == `CNT_MSB_FIRST
      |=> SDO == code_reg[RES_W-1])
      else $error("First result bit is not the MSB.");

   // Resend starts at bit one, and zeros follow it.
   a_lsb_resend: assert property (@(posedge MCLK) disable iff (!RESETN) // RL15
      state_reg == ST_ACTIVE && !sel_high && sclk_fall && cnt_reg == 5'h12
      |=> SDO == code_reg[1])
      else $error("LSB-first resend misaligned.");

   a_zero_tail: assert property (@(posedge MCLK) disable iff (!RESETN) // RL15
      state_reg == ST_ACTIVE && !sel_high && sclk_fall && cnt_reg == `CNT_ZEROS |=> !SDO)
      else $error("Tail after resend is not zero.");

endmodule

// >>> bench/spi_host_model.sv
/*
   Behavioural model of the SPI host that faces the conversion port: it
   sends leading zeros, the start bit and the command, keeps clocking for the
   result, and records data-out and its enable late in each high phase from the start bit on.
   Assumes the bench clock runs at 8 ns; every host edge lands on its falling
   edge, four bench cycles a phase, so the serial clock has a 64 ns period.
*/
`timescale 1ns/1ps

module spi_host_model (
   // Bench clock that paces the host.
   input wire logic mclk,
   // Lines driven by the host.
   output logic cs_n,
   output logic sclk,
   output logic sdi,
   // Lines driven by the device.
   input wire logic sdo,
   input wire logic sdo_oe
);
   // Data-out and enable seen at the end of each high phase from the start bit on.
   logic rec_sdo [0:39];
   logic rec_oe [0:39];

   // The link starts deselected with the serial clock parked low.
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end

   // Waits a number of falling bench clock edges.
   task automatic wait_fall(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // One serial clock; data is set while the clock is low so the device can
   // latch it on the rise, and device data is taken late in the high phase.
   task automatic pulse(input logic bit_val, input int idx);
      sclk = 1'b0;
      sdi = bit_val;
      wait_fall(4);
      sclk = 1'b1;
      wait_fall(4);
      if (idx >= 0)
      begin
         rec_sdo[idx] = sdo;
         rec_oe[idx] = sdo_oe;
      end
   endtask

   // One transaction: idle high time, select low, leading zeros, start bit,
   // mode and channel bits, then clocks with a changing don't-care input.
   task automatic frame(input logic [3:0] cmd, input int lead, input int nrise);
      int j;
      cs_n = 1'b1;
      wait_fall(64);
      cs_n = 1'b0;
      wait_fall(13);
      for (j = 0; j < lead; j++)
         pulse(1'b0, -1);
      pulse(1'b1, 0);
      for (j = 1; j <= nrise; j++)
         pulse((j <= 4) ? cmd[4 - j] : j[0], j);
      sclk = 1'b0;
      wait_fall(4);
      cs_n = 1'b1;
      wait_fall(6);
   endtask

   // Serial clocks with a high input while deselected; they must be ignored.
   task automatic idle_clocks(input int n);
      cs_n = 1'b1;
      repeat (n) pulse(1'b1, -1);
      sclk = 1'b0;
   endtask
endmodule

// >>> bench/testbench.sv
/*
   Self-checking bench of the serial conversion port: a table of commands
   covering every mode and channel, then aborted frames and ignored clocks.
   Assumes the host model drives the link and the bench drives the code.
*/
`timescale 1ns/1ps

module testbench
   import adc_port_pkg::*;
;
   // Command, converter code, leading zeros and the selection it should give.
   typedef struct packed {
      logic [3:0] cmd;
      logic [11:0] code;
      logic [1:0] lead;
      logic [6:0] mux;
   } row_t;

   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic cs_n, sclk, sdi;
   logic sdo, sdo_oe, standby, sample_open, conv_take;
   logic [11:0] conv_code = 12'h000;
   mux_sel_t mux_sel;
   row_t rows [0:15];
   int num_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   // Pulses of the code strobe and cycles of open window in one frame.
   int take_cnt = 0;
   int open_cnt = 0;
   // Cycles out of standby since the last clear.
   int act_cnt = 0;

   // The 125 MHz bench clock.
   always #4 mclk = ~mclk;

   // Counts strobes and window cycles; cuts a hang short.
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (conv_take === 1'b1)
         take_cnt <= take_cnt + 1;
      if (sample_open === 1'b1)
         open_cnt <= open_cnt + 1;
      if (standby === 1'b0)
         act_cnt <= act_cnt + 1;
      if (cyc == 20000)
      begin
         num_errors++;
         final_report();
      end
   end

   serial_adc_conversion_port #(.RES_W(12)) dut_u (
      .MCLK(mclk), .RESETN(resetn), .SELECT_AND_SLEEP_N(cs_n), .SCLK(sclk),
      .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe), .CONV_CODE(conv_code),
      .STANDBY(standby), .SAMPLE_OPEN(sample_open), .CONV_TAKE(conv_take),
      .MUX_SEL(mux_sel)
   );

   spi_host_model host_u (
      .mclk(mclk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe)
   );

   // Compares one value and reports a mismatch at once.
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Expected selection: single-ended grounds the negative side, a pair
   // takes the neighbour channel with the low bit turned round.
   function automatic logic [6:0] want_mux(input logic [3:0] c);
      if (c[3])
         return {c[2:0], 3'b000, 1'b1};
      return {c[2:0], c[2:1], ~c[0], 1'b0};
   endfunction

   // Runs one frame of nrise clocks after the start bit and checks it.
   task automatic run_row(input row_t r, input int nrise);
      int j;
      logic exp_bit;
      conv_code = r.code;
      take_cnt = 0;
      open_cnt = 0;
      act_cnt = 0;
      host_u.frame(r.cmd, int'(r.lead), nrise);
      check("left_standby", 16'(act_cnt != 0), 16'h0001);
      check("standby", standby, 1'b1);
      check("sdo_oe_off", sdo_oe, 1'b0);
      check("take_count", 16'(take_cnt), (nrise >= 5) ? 16'h0001 : 16'h0000);
      check("open_cycles", 16'(open_cnt), (nrise >= 5) ? 16'h000C : 16'h0000);
      if (nrise >= 4)
         check("mux_sel", mux_sel, r.mux);
      for (j = 0; j <= nrise; j++)
      begin
         check("sdo_oe", host_u.rec_oe[j], j >= 6);
         exp_bit = 1'b0;
         if (j >= 7 && j <= 18)
            exp_bit = r.code[18 - j];
         if (j >= 19 && j <= 29)
            exp_bit = r.code[j - 18];
         if (j >= 6)
            check("sdo", host_u.rec_sdo[j], exp_bit);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Main sequence: reset, the table, then the awkward cases.
   initial
   begin
      for (int i = 0; i < 16; i++)
         rows[i] = '{4'(i), 12'hA5C ^ 12'(i * 273), 2'(i % 3), want_mux(4'(i))};
      repeat (4) @(negedge mclk);
      check("rst_sdo", sdo, 1'b0);
      check("rst_oe", sdo_oe, 1'b0);
      check("rst_standby", standby, 1'b1);
      check("rst_open", sample_open, 1'b0);
      check("rst_take", conv_take, 1'b0);
      check("rst_mux", mux_sel, 7'h00);
      repeat (4) @(negedge mclk);
      resetn = 1'b1;
      repeat (8) @(negedge mclk);
      // Every mode and channel, with the zero tail after both result copies.
      for (int i = 0; i < 16; i++)
         run_row(rows[i], 34);
      // Deselect during the command, then during the result.
      run_row(rows[5], 3);
      run_row(rows[10], 9);
      // Clocks while deselected must neither start nor convert anything.
      take_cnt = 0;
      act_cnt = 0;
      host_u.idle_clocks(8);
      check("idle_take", 16'(take_cnt), 16'h0000);
      check("idle_active", 16'(act_cnt), 16'h0000);
      check("idle_oe", sdo_oe, 1'b0);
      check("idle_standby", standby, 1'b1);
      run_row(rows[3], 20);
      final_report();
   end
endmodule
